//--- common/sirc_cfg.svh
`ifndef SIRC_CFG_SVH
`define SIRC_CFG_SVH
// register word addresses, stage 7 block and the stage 0 base
`define SIRC_ADDR_ROUTE_LOW    10'h0b8
`define SIRC_ADDR_ROUTE_HIGH   10'h0b9
`define SIRC_ADDR_FE_OFFSET    10'h0ba
`define SIRC_ADDR_THRESH_SENS  10'h0bb
`define SIRC_ADDR_INIT_OFS_LOW 10'h0bc
`define SIRC_ADDR_INIT_OFS_HI  10'h0bd
`define SIRC_ADDR_UPPER_CLAMP  10'h0be
`define SIRC_ADDR_LOWER_CLAMP  10'h0bf
`define SIRC_ADDR_STAGE_BASE   10'h080
`define SIRC_STAGE_STRIDE      8
`define SIRC_ADDR_W            10
`define SIRC_DATA_W            16
`define SIRC_NUM_STAGES        8
`define SIRC_NUM_INPUTS        8
// field positions
`define SIRC_ROUTE_FIELD_W     2
`define SIRC_MODE_LSB          12
`define SIRC_MINUS_OFF_BIT     14
`define SIRC_PLUS_OFF_BIT      15
`define SIRC_MINUS_MAG_LSB     0
`define SIRC_PLUS_MAG_LSB      8
`define SIRC_MAG_W             6
// reset contents are undefined on the part; zero chosen here
`define SIRC_REG_RESET         16'h0000
`endif

//--- common/sirc_pkg.sv
package sirc_pkg;
   // routing of one sensor input
   typedef enum logic [1:0] {
      SIRC_ROUTE_OPEN  = 2'h0,
      SIRC_ROUTE_MINUS = 2'h1,
      SIRC_ROUTE_PLUS  = 2'h2,
      SIRC_ROUTE_BIAS  = 2'h3
   } sirc_route_t;
   // measurement mode
   typedef enum logic [1:0] {
      SIRC_MODE_RSVD  = 2'h0,
      SIRC_MODE_SE_PL = 2'h1,
      SIRC_MODE_SE_MI = 2'h2,
      SIRC_MODE_DIFF  = 2'h3
   } sirc_mode_t;
endpackage : sirc_pkg

//--- src/sirc_route_decode.sv
`timescale 1ns/1ps
`include "sirc_cfg.svh"
// one per-input switch select decoder, identical for all stages
module sirc_route_decode (
   input  wire logic [1:0] field_i,     // two-bit routing field
   output logic            to_minus_o,  // switch to converter minus
   output logic            to_plus_o,   // switch to converter plus
   output logic            to_bias_o    // switch to bias node
);
   // one-hot decode; open means all switches off
   always_comb begin
      to_minus_o = 1'b0;
      to_plus_o  = 1'b0;
      to_bias_o  = 1'b0;
      unique case (sirc_pkg::sirc_route_t'(field_i))
         sirc_pkg::SIRC_ROUTE_OPEN:  ;
         sirc_pkg::SIRC_ROUTE_MINUS: to_minus_o = 1'b1;
         sirc_pkg::SIRC_ROUTE_PLUS:  to_plus_o  = 1'b1;
         sirc_pkg::SIRC_ROUTE_BIAS:  to_bias_o  = 1'b1;
      endcase
   end
endmodule : sirc_route_decode

//--- src/sirc_stage_bank.sv
`timescale 1ns/1ps
`include "sirc_cfg.svh"
module sirc_stage_bank (
   input  wire logic        ref_clk_i,        // 25 MHz device clock
   input  wire logic        reset_n_i,        // async reset, active low
   input  wire logic        reg_wr_i,         // register write strobe
   input  wire logic        reg_rd_i,         // register read strobe
   input  wire logic [9:0]  reg_addr_i,       // register word address
   input  wire logic [15:0] reg_wdata_i,      // write data
   output logic      [15:0] reg_rdata_o,      // read data, registered
   output logic             reg_hit_o,        // address is in this bank
   input  wire logic        stage_active_i,   // sequencer is converting
   input  wire logic [2:0]  stage_sel_i,      // current stage number
   output logic      [7:0]  sw_minus_o,       // input to converter minus
   output logic      [7:0]  sw_plus_o,        // input to converter plus
   output logic      [7:0]  sw_bias_o,        // input to bias node
   output logic             mode_se_plus_o,   // single-ended, plus side
   output logic             mode_se_minus_o,  // single-ended, minus side
   output logic             mode_diff_o,      // differential mode
   output logic             mode_illegal_o,   // reserved mode programmed
   output logic             minus_ofs_en_o,   // apply minus offset
   output logic             plus_ofs_en_o,    // apply plus offset
   output logic      [5:0]  minus_mag_o,      // minus offset magnitude
   output logic      [5:0]  plus_mag_o,       // plus offset magnitude
   output logic      [15:0] sens_o,           // threshold sensitivity word
   output logic      [15:0] init_ofs_low_o,   // starting low offset
   output logic      [15:0] init_ofs_high_o,  // starting high offset
   output logic      [15:0] clamp_upper_o,    // upper offset clamp
   output logic      [15:0] clamp_lower_o     // lower offset clamp
);
   localparam int NREG = `SIRC_NUM_STAGES * `SIRC_STAGE_STRIDE;

   // address to bank index; all eight stage blocks share one map
   function automatic logic [5:0] bank_index(input logic [9:0] addr);
      logic [9:0] rel;
      rel = addr - `SIRC_ADDR_STAGE_BASE;
      return rel[5:0];
   endfunction : bank_index

   function automatic logic bank_hit(input logic [9:0] addr);
      return (addr >= `SIRC_ADDR_STAGE_BASE) &&
             (addr <= `SIRC_ADDR_LOWER_CLAMP);
   endfunction : bank_hit

   // stage register storage; the register array is indexed stage*8+word
   logic [15:0] regs_q [NREG];
   logic [15:0] regs_d [NREG];
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   assign reg_hit_o = bank_hit(reg_addr_i);

   // write path: every stage register is plain read/write
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         regs_d[i] = regs_q[i];
      end
      if (reg_wr_i && bank_hit(reg_addr_i)) begin
         // unused bits are stored as written; host keeps them zero
         regs_d[bank_index(reg_addr_i)] = reg_wdata_i;
      end
   end

   // read path: registered data, zero outside the bank
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_i) begin
         rdata_d = bank_hit(reg_addr_i) ? regs_q[bank_index(reg_addr_i)] : 16'h0000;
      end
   end

   // reset contents are undefined in the part, so zero is a safe pick
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= `SIRC_REG_RESET;
         end
         rdata_q <= 16'h0000;
      end else begin
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= regs_d[i];
         end
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // selected stage's words; stage 7 sits at 0x0b8..0x0bf
   logic [5:0]  base;
   logic [15:0] route_lo;
   logic [15:0] route_hi;
   logic [15:0] fe_ofs;
   logic [15:0] all_fields;
   assign base       = {stage_sel_i, 3'h0};
   assign route_lo   = regs_q[base];
   assign route_hi   = regs_q[base + 6'h01];
   assign fe_ofs     = regs_q[base + 6'h02];
   assign all_fields = {route_hi[1:0], route_lo[13:0]};

   // per-input switch decode, same decoder for every stage
   logic [7:0] dec_minus;
   logic [7:0] dec_plus;
   logic [7:0] dec_bias;
   for (genvar g = 0; g < `SIRC_NUM_INPUTS; g++) begin : g_in
      sirc_route_decode u_dec (
         .field_i    (all_fields[2*g +: 2]),
         .to_minus_o (dec_minus[g]),
         .to_plus_o  (dec_plus[g]),
         .to_bias_o  (dec_bias[g])
      );
   end

   // switches closed only while a stage converts; idle keeps all open
   assign sw_minus_o = stage_active_i ? dec_minus : 8'h00;
   assign sw_plus_o  = stage_active_i ? dec_plus  : 8'h00;
   assign sw_bias_o  = stage_active_i ? dec_bias  : 8'h00;

   // mode decode; reserved code raises a flag instead of a guess
   sirc_pkg::sirc_mode_t mode;
   assign mode = sirc_pkg::sirc_mode_t'(route_hi[`SIRC_MODE_LSB +: 2]);
   always_comb begin
      mode_se_plus_o  = 1'b0;
      mode_se_minus_o = 1'b0;
      mode_diff_o     = 1'b0;
      mode_illegal_o  = 1'b0;
      unique case (mode)
         sirc_pkg::SIRC_MODE_RSVD:  mode_illegal_o  = 1'b1;
         sirc_pkg::SIRC_MODE_SE_PL: mode_se_plus_o  = 1'b1;
         sirc_pkg::SIRC_MODE_SE_MI: mode_se_minus_o = 1'b1;
         sirc_pkg::SIRC_MODE_DIFF:  mode_diff_o     = 1'b1;
      endcase
   end

   // offset gating: a set bit disables
   assign minus_ofs_en_o = ~route_hi[`SIRC_MINUS_OFF_BIT];
   assign plus_ofs_en_o  = ~route_hi[`SIRC_PLUS_OFF_BIT];
   assign minus_mag_o    = fe_ofs[`SIRC_MINUS_MAG_LSB +: `SIRC_MAG_W];
   assign plus_mag_o     = fe_ofs[`SIRC_PLUS_MAG_LSB +: `SIRC_MAG_W];

   // remaining stage words passed to calibration logic
   assign sens_o          = regs_q[base + 6'h03];
   assign init_ofs_low_o  = regs_q[base + 6'h04];
   assign init_ofs_high_o = regs_q[base + 6'h05];
   assign clamp_upper_o   = regs_q[base + 6'h06];
   assign clamp_lower_o   = regs_q[base + 6'h07];
endmodule : sirc_stage_bank

//--- tb/sirc_stage_bank_chk.sv
`timescale 1ns/1ps
// watches the bank at its ports only
module sirc_stage_bank_chk (
   input wire logic        ref_clk_i, reset_n_i, reg_wr_i, reg_rd_i, reg_hit_o,
   input wire logic [9:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i, reg_rdata_o,
   input wire logic        stage_active_i,
   input wire logic [2:0]  stage_sel_i,
   input wire logic [7:0]  sw_minus_o, sw_plus_o, sw_bias_o,
   input wire logic        mode_se_plus_o, mode_se_minus_o, mode_diff_o, mode_illegal_o,
   input wire logic        minus_ofs_en_o, plus_ofs_en_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // readback of a written word two cycles later
   AST_READBACK: assert property (
      reg_wr_i && reg_hit_o && !reg_rd_i ##1 !reg_wr_i
      ##1 reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i, 2)
      |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("readback differs");
   AST_MISS_READ: assert property (
      reg_rd_i && !reg_hit_o |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   AST_HIT: assert property (
      reg_hit_o == (reg_addr_i inside {[10'h080:10'h0bf]}))
      else $error("address decode wrong");
   AST_RD_HOLD: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   // switches open whenever the sequencer is idle
   AST_IDLE: assert property (
      !stage_active_i |-> (sw_minus_o | sw_plus_o | sw_bias_o) == 8'h00)
      else $error("switch closed while idle");
   AST_ONE_PATH: assert property (
      (sw_minus_o & sw_plus_o) == 8'h00
      && (sw_plus_o & sw_bias_o) == 8'h00 && (sw_minus_o & sw_bias_o) == 8'h00)
      else $error("input on two nodes");
   AST_PLUS_SW: assert property (
      reg_wr_i && reg_addr_i == 10'h0b8 ##1 stage_active_i
      && stage_sel_i == 3'h7 |-> sw_plus_o[0] == ($past(reg_wdata_i[1:0]) == 2'h2))
      else $error("input 0 plus switch wrong");
   AST_MODE: assert property (
      $onehot({mode_se_plus_o, mode_se_minus_o, mode_diff_o, mode_illegal_o}))
      else $error("mode flags not one-hot");
   AST_OFS_EN: assert property (
      reg_wr_i && reg_addr_i == 10'h0b9 ##1 stage_sel_i == 3'h7
      |-> {plus_ofs_en_o, minus_ofs_en_o} == ~$past(reg_wdata_i[15:14]))
      else $error("offset gates wrong");
endmodule : sirc_stage_bank_chk
bind sirc_stage_bank sirc_stage_bank_chk i_chk (.*);

//--- tb/sirc_stage_bank_tb.sv
`timescale 1ns/1ps
module sirc_stage_bank_tb;
   logic        clk, rst_n, wr, rd, act, mp, mm, md, mi, moe, poe, hit;
   logic [9:0]  addr;
   logic [15:0] wdata, rdata, sens, iol, ioh, cu, cl;
   logic [2:0]  sel;
   logic [7:0]  smi, spl, sbi;
   logic [5:0]  mmag, pmag;
   logic [1:0]  c;
   int          failures = 0;
   int          check_count = 0;
   sirc_stage_bank i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit),
      .stage_active_i(act), .stage_sel_i(sel), .sw_minus_o(smi), .sw_plus_o(spl),
      .sw_bias_o(sbi), .mode_se_plus_o(mp), .mode_se_minus_o(mm), .mode_diff_o(md),
      .mode_illegal_o(mi), .minus_ofs_en_o(moe), .plus_ofs_en_o(poe), .minus_mag_o(mmag),
      .plus_mag_o(pmag), .sens_o(sens), .init_ofs_low_o(iol), .init_ofs_high_o(ioh),
      .clamp_upper_o(cu), .clamp_lower_o(cl));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one strobe cycle, inputs move 1 ns after the edge
   task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk); #1;
      wr = 1'b1; addr = a; wdata = d;
      @(posedge clk); #1;
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [9:0] a, input logic [15:0] exp, input string what);
      @(posedge clk); #1;
      rd = 1'b1; addr = a;
      @(posedge clk); #1;
      rd = 1'b0;
      chk(rdata, exp, what);
   endtask : rd_reg
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // watchdog, far beyond the roughly seventy cycles the tests need
   initial begin
      #50000;
      failures++;
      tally_and_finish();
   end
   initial begin
      rst_n = 1'b0; wr = 1'b0; rd = 1'b0; act = 1'b1; sel = 3'h7; addr = 10'h0; wdata = 16'h0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      rd_reg(10'h0b8, 16'h0000, "route_low_rst");
      chk({15'h0, mi}, 16'h0001, "illegal_rst");
      // all eight words, then their readback and output copies
      for (int i = 0; i < 8; i++) wr_reg(10'h0b8 + 10'(i), 16'h5a00 + 16'(i));
      for (int i = 0; i < 8; i++) rd_reg(10'h0b8 + 10'(i), 16'h5a00 + 16'(i), "word");
      chk({pmag, 2'h0, mmag}, {6'h1a, 2'h0, 6'h02}, "magnitudes");
      chk(sens ^ iol ^ ioh, 16'h5a02, "sens_ofs");
      chk(cu ^ cl, 16'h0001, "clamps");
      $display("test registers done");
      // every routing code, mode code and offset gate
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         wr_reg(10'h0b8, {2'h0, {7{c}}});
         wr_reg(10'h0b9, {c, c, 10'h000, c});
         chk({sbi, spl}, {{8{c == 2'h3}}, {8{c == 2'h2}}}, "bias_plus");
         chk({8'h0, smi}, {8'h0, {8{c == 2'h1}}}, "minus");
         chk({12'h0, mp, mm, md, mi}, {12'h0, c == 2'h1, c == 2'h2, c == 2'h3, c == 2'h0},
             "mode");
         chk({14'h0, poe, moe}, {14'h0, ~c[1], ~c[0]}, "ofs_en");
         rd_reg(10'h0b9, {c, c, 10'h000, c}, "route_high");
      end
      $display("test routing done");
      // stage 0 decodes with the same layout
      sel = 3'h0;
      wr_reg(10'h080, 16'h0006);
      wr_reg(10'h081, 16'h1000);
      chk({smi, spl}, 16'h0201, "stage0_sw");
      chk({12'h0, mp, mm, md, mi}, 16'h0008, "stage0_mode");
      act = 1'b0;
      #1 chk({smi, spl}, 16'h0000, "idle_sw");
      $display("test stage0 done");
      // outside the bank nothing is stored
      wr_reg(10'h0c0, 16'hffff);
      rd_reg(10'h0c0, 16'h0000, "unmapped");
      chk({15'h0, hit}, 16'h0000, "hit_unmapped");
      $display("test unmapped done");
      tally_and_finish();
   end
endmodule : sirc_stage_bank_tb
